// File: rtl/sabs_params.svh
// Purpose: Named constants for the automatic serial transfer sync and timing block.
// Assumes: Included by bare name wherever the constants are needed.
// Notes:   Bit positions refer to the control and interval register images on the ports.
`ifndef SABS_PARAMS_SVH
`define SABS_PARAMS_SVH

`define SABS_BITS_PER_BYTE   4'h8
`define SABS_GAP_MIN         7'h02
`define SABS_BUSY_CHK_GAP    8'h02
`define SABS_MASTER_IRQ_RISE 8'h02
`define SABS_INTV_SEL_BIT    7
`define SABS_INTV_MSB        6
`define SABS_ERR_BIT         4
`define SABS_SEN_BIT         7
`define SABS_CNT_ZERO        4'h0
`define SABS_CNT_ONE         4'h1
`define SABS_GAP_ZERO        8'h00
`define SABS_GAP_ONE         8'h01

`endif

// File: rtl/sabs_pkg.sv
// Purpose: Types shared by the automatic serial transfer sync and timing block.
// Assumes: Compiled before the design module.
// Notes:   Sequencer states are binary coded.
package sabs_pkg;

  typedef enum logic [2:0] {
    SABS_IDLE   = 3'h0,
    SABS_LAUNCH = 3'h1,
    SABS_BYTE   = 3'h2,
    SABS_GAP    = 3'h3,
    SABS_WAIT   = 3'h4,
    SABS_TAIL   = 3'h5
  } sabs_state_e;

endpackage

// File: rtl/sabs_sync_timing.sv
// Purpose: Busy handshake, bit-shift check, interrupt timing and inter-byte gap of an
//          automatic buffer-driven serial transfer unit acting as master.
// Assumes: sck_i is the internal serial clock, slow against clk_i; busy_i is asynchronous.
// Notes:   Bytes start on a falling serial clock edge and complete on the eighth rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "sabs_params.svh"

// Notes on behaviour
// - When sampled busy goes inactive, wait ends; next byte starts at following falling edge.
// - Busy release is seen within one serial clock; transfer starts one clock later.
// - With error check enabled, busy is sampled at the eighth falling edge of each byte.
// - Busy active there sets error flag, clears serial enable, raises interrupt at rise eight.
// - Single mode master raises interrupt at tenth rising edge ending the transfer.
// - Single mode slave raises interrupt at eighth rising edge ending the transfer.
// - A detected bit shift raises the interrupt at the eighth rising edge.
// - Interval select clear gives a gap of two serial clocks between bytes.
// - Interval select set gives the larger of programmed interval and two clocks.
// - Busy control acts only with auto transfer and busy enable set, internal clock, interval select clear.
// - Busy polarity select chooses the active level of the busy input.
// - Busy ignored in a byte; valid only if active two falls after completion.
// - Repeat mode raises no end interrupt; pointer reloads and transmission continues.
module sabs_sync_timing (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       busy_i,
  input  wire logic       start_i,
  input  wire logic       last_byte_i,
  input  wire logic       repeat_mode_i,
  input  wire logic       slave_mode_i,
  input  wire logic       internal_clock_i,
  input  wire logic       auto_transfer_enable_i,
  input  wire logic       busy_polarity_sel_i,
  input  wire logic       busy_check_enable_i,
  input  wire logic       error_check_enable_i,
  input  wire logic [7:0] transfer_interval_register_i,
  input  wire logic       serial_enable_wr_i,
  input  wire logic       serial_enable_wdata_i,
  input  wire logic       err_clr_i,
  output logic            serial_enable_o,
  output logic            err_flag_o,
  output logic            transfer_active_flag_o,
  output logic            shift_fall_o,
  output logic            shift_rise_o,
  output logic            load_next_o,
  output logic            byte_done_o,
  output logic            pointer_reload_o,
  output logic            serial_irq_flag_o,
  output logic            waiting_o
);
  import sabs_pkg::*;

  // Active level of busy: selector clear means active high.
  function automatic logic busy_level(input logic raw, input logic pol);
    busy_level = raw ^ pol;
  endfunction

  // Gap length in serial clocks, never below the minimum.
  function automatic logic [6:0] gap_length(input logic [7:0] intv);
    logic [6:0] prog;
    prog = intv[`SABS_INTV_MSB:0];
    if (!intv[`SABS_INTV_SEL_BIT] || prog < `SABS_GAP_MIN) begin
      gap_length = `SABS_GAP_MIN;
    end else begin
      gap_length = prog;
    end
  endfunction

  logic        sck_s1, sck_s2, sck_s3;
  logic        busy_s1, busy_s2;
  sabs_state_e state, next_state;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  gap_cnt, next_gap_cnt;
  logic        chk_hit, next_chk_hit;
  logic        sen, next_sen;
  logic        err, next_err;
  logic        load_p, next_load_p;
  logic        done_p, next_done_p;
  logic        reload_p, next_reload_p;
  logic        irq_p, next_irq_p;
  logic        fall_p, next_fall_p;
  logic        rise_p, next_rise_p;

  logic        sck_rise, sck_fall, busy_act, busy_ctl;
  logic [7:0]  gap_inc;

  // Second stages and the third serial clock stage feed logic; first stages are read by nothing else.
  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign busy_act = busy_level(busy_s2, busy_polarity_sel_i);
  assign busy_ctl = auto_transfer_enable_i && busy_check_enable_i && internal_clock_i
                    && !transfer_interval_register_i[`SABS_INTV_SEL_BIT];
  assign gap_inc  = gap_cnt + `SABS_GAP_ONE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s1  <= 1'b1;
      sck_s2  <= 1'b1;
      sck_s3  <= 1'b1;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      sck_s1  <= sck_i;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      busy_s1 <= busy_i;
      busy_s2 <= busy_s1;
    end
  end

  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_gap_cnt  = gap_cnt;
    next_chk_hit  = chk_hit;
    next_sen      = sen;
    next_err      = err;
    next_load_p   = 1'b0;
    next_done_p   = 1'b0;
    next_reload_p = 1'b0;
    next_irq_p    = 1'b0;
    next_fall_p   = 1'b0;
    next_rise_p   = 1'b0;

    if (serial_enable_wr_i) begin
      next_sen = serial_enable_wdata_i;
    end
    if (err_clr_i) begin
      next_err = 1'b0;
    end

    unique case (state)
      SABS_IDLE: begin
        next_chk_hit = 1'b0;
        if (start_i && sen) begin
          next_state = SABS_LAUNCH;
        end
      end
      SABS_LAUNCH: begin
        if (sck_fall) begin
          next_state   = SABS_BYTE;
          next_bit_cnt = `SABS_CNT_ONE;
          next_load_p  = 1'b1;
          next_fall_p  = 1'b1;
        end
      end
      SABS_BYTE: begin
        if (sck_fall) begin
          next_bit_cnt = bit_cnt + `SABS_CNT_ONE;
          next_fall_p  = 1'b1;
          if (bit_cnt + `SABS_CNT_ONE == `SABS_BITS_PER_BYTE) begin
            next_chk_hit = error_check_enable_i && busy_act;
          end
        end else if (sck_rise) begin
          next_rise_p = 1'b1;
          if (bit_cnt == `SABS_BITS_PER_BYTE) begin
            next_done_p  = 1'b1;
            next_bit_cnt = `SABS_CNT_ZERO;
            next_gap_cnt = `SABS_GAP_ZERO;
            next_chk_hit = 1'b0;
            if (chk_hit) begin
              next_err   = 1'b1;
              next_sen   = 1'b0;
              next_irq_p = 1'b1;
              next_state = SABS_IDLE;
            end else if (last_byte_i && repeat_mode_i) begin
              next_reload_p = 1'b1;
              next_state    = sen ? SABS_GAP : SABS_IDLE;
            end else if (last_byte_i) begin
              if (slave_mode_i) begin
                next_irq_p = 1'b1;
                next_state = SABS_IDLE;
              end else begin
                next_state = SABS_TAIL;
              end
            end else begin
              next_state = sen ? SABS_GAP : SABS_IDLE;
            end
          end
        end
      end
      SABS_TAIL: begin
        if (sck_rise) begin
          next_gap_cnt = gap_inc;
          if (gap_inc == `SABS_MASTER_IRQ_RISE) begin
            next_irq_p = 1'b1;
            next_state = SABS_IDLE;
          end
        end
      end
      SABS_GAP: begin
        if (sck_fall) begin
          next_gap_cnt = gap_inc;
          if (gap_inc == `SABS_BUSY_CHK_GAP && busy_ctl && busy_act) begin
            next_state = SABS_WAIT;
          end else if (gap_inc > {1'b0, gap_length(transfer_interval_register_i)}) begin
            next_state   = SABS_BYTE;
            next_bit_cnt = `SABS_CNT_ONE;
            next_load_p  = 1'b1;
            next_fall_p  = 1'b1;
          end
        end
      end
      SABS_WAIT: begin
        if (sck_fall && !(busy_ctl && busy_act)) begin
          next_state = SABS_LAUNCH;
        end
      end
      default: begin
        next_state = SABS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= SABS_IDLE;
      bit_cnt  <= `SABS_CNT_ZERO;
      gap_cnt  <= `SABS_GAP_ZERO;
      chk_hit  <= 1'b0;
      sen      <= 1'b0;
      err      <= 1'b0;
      load_p   <= 1'b0;
      done_p   <= 1'b0;
      reload_p <= 1'b0;
      irq_p    <= 1'b0;
      fall_p   <= 1'b0;
      rise_p   <= 1'b0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      gap_cnt  <= next_gap_cnt;
      chk_hit  <= next_chk_hit;
      sen      <= next_sen;
      err      <= next_err;
      load_p   <= next_load_p;
      done_p   <= next_done_p;
      reload_p <= next_reload_p;
      irq_p    <= next_irq_p;
      fall_p   <= next_fall_p;
      rise_p   <= next_rise_p;
    end
  end

  assign serial_enable_o        = sen;
  assign err_flag_o             = err;
  assign transfer_active_flag_o = (state != SABS_IDLE);
  assign shift_fall_o           = fall_p;
  assign shift_rise_o           = rise_p;
  assign load_next_o            = load_p;
  assign byte_done_o            = done_p;
  assign pointer_reload_o       = reload_p;
  assign serial_irq_flag_o      = irq_p;
  assign waiting_o              = (state == SABS_WAIT);

endmodule

`default_nettype wire

// File: test/sabs_assertions.sv
// Purpose: Port-level timing checks for the serial sync block.
// Assumes: One serial clock lasts SCK_CLKS system clocks.
// Notes:   Bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module sabs_assertions #(
  parameter int SCK_CLKS = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       slave_mode_i,
  input wire logic [7:0] transfer_interval_register_i,
  input wire logic       serial_enable_o,
  input wire logic       err_flag_o,
  input wire logic       shift_fall_o,
  input wire logic       shift_rise_o,
  input wire logic       load_next_o,
  input wire logic       byte_done_o,
  input wire logic       pointer_reload_o,
  input wire logic       serial_irq_flag_o,
  input wire logic       waiting_o
);
  localparam int EXIT_MAX = SCK_CLKS + 2;
  logic [3:0] rises;
  logic [9:0] gap;
  logic       gap_ok;
  logic [6:0] len;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign len = (transfer_interval_register_i[7] && transfer_interval_register_i[6:0] > 7'h02) ?
               transfer_interval_register_i[6:0] : 7'h02;
  // Gap timing is only judged between two bytes of one run with no wait.
  always_ff @(posedge clk_i) begin
    rises  <= (rst_i || load_next_o) ? 4'h0 : rises + {3'h0, shift_rise_o};
    gap    <= byte_done_o ? 10'h001 : gap + 10'h001;
    gap_ok <= !rst_i && serial_enable_o && !serial_irq_flag_o &&
              (byte_done_o || (gap_ok && !waiting_o && !load_next_o));
  end
  sequence s_next_byte;
    ##[1:EXIT_MAX] load_next_o;
  endsequence
  a_byte_rises: assert property (byte_done_o |-> rises + {3'h0, shift_rise_o} == 4'h8)
    else $error("byte length wrong");
  a_gap_len: assert property (load_next_o && gap_ok |-> gap == 10'(SCK_CLKS / 2 + SCK_CLKS * int'(len)))
    else $error("gap length wrong");
  a_err_step: assert property ($rose(err_flag_o) |-> serial_irq_flag_o && !serial_enable_o)
    else $error("error step incomplete");
  a_reload_quiet: assert property (pointer_reload_o |-> !serial_irq_flag_o ##16 !serial_irq_flag_o)
    else $error("irq in repeat mode");
  a_slave_irq: assert property (serial_irq_flag_o && slave_mode_i |-> byte_done_o || $rose(err_flag_o))
    else $error("slave irq off the eighth rise");
  a_master_irq: assert property (serial_irq_flag_o && !slave_mode_i && !$rose(err_flag_o) |->
                                 $past(byte_done_o, 2 * SCK_CLKS))
    else $error("master irq off the tenth rise");
  a_wait_hold: assert property (waiting_o |-> !load_next_o && !shift_fall_o)
    else $error("byte began while waiting");
  a_wait_exit: assert property ($fell(waiting_o) && serial_enable_o |-> s_next_byte)
    else $error("byte late after wait");
endmodule
bind sabs_sync_timing sabs_assertions #(.SCK_CLKS(8)) u_chk (.*);
`default_nettype wire

// File: test/sabs_slave_model.sv
// Purpose: Slave end of the link, driving the busy line.
// Assumes: sof_i rises before the first rising serial edge of a byte.
// Notes:   early_i mimics a slave that slipped one bit.
`timescale 1ns/1ps
`default_nettype none
module sabs_slave_model (
  input  wire logic       sck_i,
  input  wire logic       sof_i,
  input  wire logic       pol_i,
  input  wire logic       early_i,
  input  wire logic [3:0] hold_i,
  output logic            busy_o
);
  logic [3:0] bits;
  logic [3:0] left;
  initial begin
    bits = 4'h0;
    left = 4'h0;
  end
  always @(posedge sof_i) begin
    bits = 4'h0;
  end
  always @(posedge sck_i) begin
    bits = bits + 4'h1;
    if (left != 4'h0) begin
      left = left - 4'h1;
    end
    if (bits == (early_i ? 4'h7 : 4'h8)) begin
      left = hold_i;
    end
  end
  assign busy_o = (left != 4'h0) ^ pol_i;
endmodule
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for the serial sync and timing block.
// Assumes: Free serial clock of 320 ns, out of phase with the system clock.
// Notes:   Event counts and flags are compared after each run.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_i = 1'b0;
  logic       sck_i = 1'b1;
  logic       rst_i, busy_i, start_i, last_byte_i, repeat_mode_i, slave_mode_i, early, clr;
  logic       busy_polarity_sel_i, busy_check_enable_i, error_check_enable_i, err_clr_i;
  logic       serial_enable_wr_i, serial_enable_wdata_i, serial_enable_o, err_flag_o;
  logic       transfer_active_flag_o, shift_fall_o, shift_rise_o, load_next_o, byte_done_o;
  logic       pointer_reload_o, serial_irq_flag_o, waiting_o, in_gap;
  logic       internal_clock_i = 1'b1;
  logic       auto_transfer_enable_i = 1'b1;
  logic [7:0] transfer_interval_register_i, n_irq, n_wait, n_rel, n_gap;
  logic [3:0] hold;
  int         failures, total_checks, cyc;
  sabs_sync_timing u_dut (.*);
  sabs_slave_model u_slave (.sck_i(sck_i), .sof_i(load_next_o), .pol_i(busy_polarity_sel_i),
                            .early_i(early), .hold_i(hold), .busy_o(busy_i));
  always #20 clk_i = ~clk_i;
  initial begin
    #7;
    forever #160 sck_i = ~sck_i;
  end
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [4:0] m, input logic [7:0] iv, input logic [3:0] h, input logic e);
    {slave_mode_i, repeat_mode_i, busy_check_enable_i, busy_polarity_sel_i, error_check_enable_i} <= m;
    {transfer_interval_register_i, hold, early} <= {iv, h, e};
    {serial_enable_wr_i, serial_enable_wdata_i, err_clr_i, clr} <= 4'hF;
    @(posedge clk_i);
    {serial_enable_wr_i, err_clr_i, clr} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic run(input int n);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (int i = 0; i < n; i++) begin
      while (!load_next_o) @(posedge clk_i);
      last_byte_i <= (i == n - 1);
      while (!byte_done_o && !err_flag_o) @(posedge clk_i);
      @(posedge clk_i);
      last_byte_i <= 1'b0;
    end
    if (repeat_mode_i) begin
      {serial_enable_wr_i, serial_enable_wdata_i} <= 2'h2;
      @(posedge clk_i);
      serial_enable_wr_i <= 1'b0;
    end
    repeat (100) @(posedge clk_i);
  endtask
  // Event counters and the hang limit.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    n_irq <= clr ? 8'h00 : n_irq + {7'h0, serial_irq_flag_o};
    n_wait <= clr ? 8'h00 : n_wait + {7'h0, waiting_o};
    n_rel <= clr ? 8'h00 : n_rel + {7'h0, pointer_reload_o};
    // Cycles spent between a byte end and the next byte start or the end interrupt.
    in_gap <= !clr && !load_next_o && !serial_irq_flag_o && (byte_done_o || in_gap);
    n_gap <= clr ? 8'h00 : n_gap + {7'h0, in_gap};
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    {rst_i, start_i, last_byte_i, serial_enable_wr_i, serial_enable_wdata_i, err_clr_i, clr} = 7'h41;
    {slave_mode_i, repeat_mode_i, busy_check_enable_i, busy_polarity_sel_i, error_check_enable_i} = 5'h00;
    {transfer_interval_register_i, hold, early} = 13'h0000;
    {failures, total_checks, cyc} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    cfg(5'h00, 8'h00, 4'h0, 1'b0);
    run(2);
    chk(n_irq, 8'h01);
    chk(n_gap, 8'h24);
    cfg(5'h10, 8'h00, 4'h0, 1'b0);
    run(1);
    chk(n_irq, 8'h01);
    for (int i = 0; i < 2; i++) begin
      cfg(5'h00, (i == 0) ? 8'h81 : 8'h85, 4'h0, 1'b0);
      run(2);
      chk(n_irq, 8'h01);
      chk(n_gap, (i == 0) ? 8'h24 : 8'h3C);
    end
    for (int p = 0; p < 2; p++) begin
      cfg({3'h1, 1'(p), 1'b0}, 8'h00, 4'h5, 1'b0);
      run(2);
      chk(8'(n_wait != 8'h00), 8'h01);
    end
    cfg(5'h04, 8'h00, 4'h1, 1'b0);
    run(2);
    chk(n_wait, 8'h00);
    cfg(5'h04, 8'h82, 4'h5, 1'b0);
    run(2);
    chk(n_wait, 8'h00);
    // Busy control needs both the internal clock and the auto transfer enable.
    for (int k = 0; k < 2; k++) begin
      {internal_clock_i, auto_transfer_enable_i} <= (k == 0) ? 2'h1 : 2'h2;
      cfg(5'h04, 8'h00, 4'h5, 1'b0);
      run(2);
      chk(n_wait, 8'h00);
    end
    {internal_clock_i, auto_transfer_enable_i} <= 2'h3;
    cfg(5'h08, 8'h00, 4'h0, 1'b0);
    run(3);
    chk(n_rel, 8'h01);
    chk(n_irq, 8'h00);
    chk(8'(transfer_active_flag_o), 8'h00);
    cfg(5'h01, 8'h00, 4'h1, 1'b0);
    run(1);
    chk(8'(err_flag_o), 8'h00);
    cfg(5'h01, 8'h00, 4'h3, 1'b1);
    run(1);
    chk(8'(err_flag_o), 8'h01);
    chk(8'(serial_enable_o), 8'h00);
    chk(n_irq, 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
